// ---- core/acsp_pkg.sv ----
package acsp_pkg;
  localparam int CLK_MHZ = 100;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 11;
  localparam logic [4:0] ADDR_PWR = 5'h00;
  localparam logic [4:0] ADDR_TEST = 5'h0A;
  localparam logic [4:0] ADDR_MODE = 5'h0D;
  localparam logic [10:0] REG_RESET = 11'h000;
  localparam int B_PDG = 0;
  localparam int B_CHPD = 1;
  localparam int B_REF = 5;
  localparam int B_RST = 10;
  localparam int B_WIRE = 0;
  localparam int B_RATE = 1;
  localparam int B_SER = 2;
  localparam int B_EDGE = 4;
  localparam int B_GAIN = 5;
  localparam int B_ORDER = 6;
  localparam int B_OVRD = 10;
  localparam int B_PAT = 5;
  localparam int B_DF = 9;
  localparam logic [2:0] PAT_NORMAL = 3'h0;
  localparam logic [2:0] PAT_SYNC = 3'h1;
  localparam logic [2:0] PAT_DESKEW = 3'h2;
  localparam logic [1:0] LVL_GND = 2'h0;
  localparam logic [1:0] LVL_3_8 = 2'h1;
  localparam logic [1:0] LVL_5_8 = 2'h2;
  localparam logic [1:0] LVL_FULL = 2'h3;
  localparam int T_EFFECT_NS = 100;
  localparam int SYNC_LAT = 3;
  localparam logic [3:0] WR_DLY_CYC = 4'((T_EFFECT_NS * CLK_MHZ) / 1000 - SYNC_LAT);
  localparam int T_HALF_NS = 30;
  localparam logic [3:0] HALF_CYC = 4'((T_HALF_NS * CLK_MHZ + 999) / 1000);
  localparam int T_SEN_NS = 25;
  localparam logic [3:0] SEN_CYC = 4'((T_SEN_NS * CLK_MHZ + 999) / 1000);
  localparam int T_RST_PULSE_NS = 20;
  localparam logic [3:0] RST_PULSE_CYC = 4'((T_RST_PULSE_NS * CLK_MHZ + 999) / 1000);
  localparam int T_RST_SEN_NS = 25;
  localparam logic [3:0] RST_SEN_CYC = 4'((T_RST_SEN_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] HOST_CMD = 8'h00;
  localparam logic [7:0] HOST_STAT = 8'h04;
  localparam logic [7:0] HOST_PINS = 8'h08;
  localparam int P_PDN = 8;
  localparam int P_PAR = 9;
  localparam int P_SCLK = 10;
  localparam int P_SDAT = 11;
  localparam int P_RST = 12;
  localparam logic [12:0] PINS_RESET = 13'h0000;
endpackage

// ---- core/acsp_if.sv ----
`timescale 1ns/1ps
interface acsp_if;
  logic sclk;
  logic serial_select_n;
  logic serial_data_in;
  logic hw_reset;
  logic pdn_pin;
  logic [1:0] select_level;
  logic [1:0] wire_clock_strap;
  logic [1:0] serialize_edge_strap;
  logic [1:0] reserved_strap;
  logic [1:0] order_format_strap;
  modport dev (
    input sclk,
    input serial_select_n,
    input serial_data_in,
    input hw_reset,
    input pdn_pin,
    input select_level,
    input wire_clock_strap,
    input serialize_edge_strap,
    input reserved_strap,
    input order_format_strap
  );
  modport host (
    output sclk,
    output serial_select_n,
    output serial_data_in,
    output hw_reset,
    output pdn_pin,
    output select_level,
    output wire_clock_strap,
    output serialize_edge_strap,
    output reserved_strap,
    output order_format_strap
  );
endinterface

// ---- core/acsp_dev.sv ----
`timescale 1ns/1ps
// How it works
// RULE1: Override bit picks registers, else strap modes
// RULE2: Power-down pin forces global power down
// RULE3: Coarse gain from register only with override
// RULE4: Reference select from power register bit
// RULE5: Test register bits pick output pattern
// RULE6: Strap-only clock/data pins select pattern, power
// RULE7: Select level sets reference and gain
// RULE8: Wire/clock strap decode
// RULE9: Serialize/edge strap decode, edge SDR only
// RULE10: Order/format strap decode
// RULE11: Host grounds the reserved strap
// RULE12: Configure from pins after power-up
// RULE13: Shift on falling clock while select low
// RULE14: Commit word every sixteenth falling edge
// RULE15: Trailing partial bits are dropped
// RULE16: Five address bits then eleven data
// RULE17: Any clock rate up to 20 MHz
// RULE18: Hardware reset pulse restores defaults
// RULE19: Soft reset bit restores defaults, self-clears
// RULE20: Host holds hardware reset low unused
// RULE21: Write takes effect about 100 ns later
// RULE22: Host waits 25 ns before select low
// RULE23: Host sets override for serial-only use; acsp_host leaves it to ADDR_MODE words written to HOST_CMD
// RULE24: Select rise discards partial word
module acsp_dev
  import acsp_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  acsp_if.dev link,
  output logic two_wire,
  output logic ddr_clock,
  output logic ser_14x,
  output logic capture_rising,
  output logic lsb_first,
  output logic offset_binary,
  output logic gain_35db,
  output logic ref_internal,
  output logic global_pd,
  output logic [3:0] chan_pd,
  output logic [2:0] pattern
);

  typedef struct packed {
    logic [1:0] m_sclk;
    logic sclk_old;
    logic [1:0] m_sen;
    logic [1:0] m_sdat;
    logic [1:0] m_hrst;
    logic [1:0] m_pdn;
    logic [3:0][1:0] m_lvl0;
    logic [3:0][1:0] m_lvl1;
    logic [15:0] shift;
    logic [3:0] bits;
    logic [15:0] hold;
    logic pend;
    logic [3:0] wait_cnt;
    logic [10:0] r_pwr;
    logic [10:0] r_test;
    logic [10:0] r_mode;
    logic two_wire;
    logic ddr_clock;
    logic ser_14x;
    logic capture_rising;
    logic lsb_first;
    logic offset_binary;
    logic gain_35db;
    logic ref_internal;
    logic global_pd;
    logic [3:0] chan_pd;
    logic [2:0] pattern;
  } acsp_dev_s;

  acsp_dev_s q;
  acsp_dev_s next_q;

  always_comb begin
    logic fall;
    logic par;
    logic ovrd;
    logic [1:0] sel;
    logic [1:0] wc;
    logic [1:0] se;
    logic [1:0] of;
    logic s_ddr;
    logic s_two;
    logic s_14x;
    logic s_rise;
    logic s_lsb;
    logic s_ob;
    logic s_int;
    logic s_gain;
    logic ddr;
    logic pd_sw;
    logic [4:0] addr;
    logic [10:0] data;
    fall = 1'b0;
    par = 1'b0;
    ovrd = 1'b0;
    sel = LVL_GND;
    wc = LVL_GND;
    se = LVL_GND;
    of = LVL_GND;
    s_ddr = 1'b0;
    s_two = 1'b0;
    s_14x = 1'b0;
    s_rise = 1'b0;
    s_lsb = 1'b0;
    s_ob = 1'b0;
    s_int = 1'b0;
    s_gain = 1'b0;
    ddr = 1'b0;
    pd_sw = 1'b0;
    addr = q.hold[15:11];
    data = q.hold[10:0];
    next_q = q;

    // Pins cross into mclk; clock phases must each exceed a few mclk periods
    next_q.m_sclk = {q.m_sclk[0], link.sclk}; // RULE17
    next_q.sclk_old = q.m_sclk[1];
    next_q.m_sen = {q.m_sen[0], link.serial_select_n};
    next_q.m_sdat = {q.m_sdat[0], link.serial_data_in};
    next_q.m_hrst = {q.m_hrst[0], link.hw_reset};
    next_q.m_pdn = {q.m_pdn[0], link.pdn_pin};
    next_q.m_lvl0 = {link.order_format_strap, link.serialize_edge_strap,
                     link.wire_clock_strap, link.select_level};
    next_q.m_lvl1 = q.m_lvl0;

    fall = q.sclk_old & ~q.m_sclk[1];
    par = q.m_hrst[1];

    // Commit waits so the new setting lands near the documented delay
    if (q.pend) begin
      if (q.wait_cnt == 4'h0) begin
        next_q.pend = 1'b0; // RULE21
        case (addr) // RULE16
          ADDR_PWR: begin
            if (data[B_RST]) begin
              next_q.r_pwr = REG_RESET; // RULE19
              next_q.r_test = REG_RESET;
              next_q.r_mode = REG_RESET;
            end else begin
              next_q.r_pwr = data;
            end
          end
          ADDR_TEST: begin
            next_q.r_test = data;
          end
          ADDR_MODE: begin
            next_q.r_mode = data;
          end
          default: begin
          end
        endcase
      end else begin
        next_q.wait_cnt = q.wait_cnt - 4'h1;
      end
    end

    if (par || q.m_sen[1]) begin
      next_q.bits = 4'h0; // RULE24 RULE15
    end else if (fall) begin
      next_q.shift = {q.shift[14:0], q.m_sdat[1]}; // RULE13
      next_q.bits = q.bits + 4'h1;
      if (q.bits == 4'hF) begin
        next_q.hold = {q.shift[14:0], q.m_sdat[1]}; // RULE14
        next_q.pend = 1'b1;
        next_q.wait_cnt = WR_DLY_CYC - 4'h1;
      end
    end

    // Reset pin held high doubles as strap-only mode
    if (par) begin
      next_q.r_pwr = REG_RESET; // RULE18
      next_q.r_test = REG_RESET;
      next_q.r_mode = REG_RESET;
      next_q.pend = 1'b0;
    end

    // Straps are decoded live so power-up needs no reset
    sel = q.m_lvl1[0]; // RULE12
    wc = q.m_lvl1[1];
    se = q.m_lvl1[2];
    of = q.m_lvl1[3];

    case (wc) // RULE8
      LVL_GND, LVL_3_8: begin
        s_ddr = 1'b1;
        s_two = 1'b0;
      end
      LVL_5_8: begin
        s_ddr = 1'b0;
        s_two = 1'b1;
      end
      default: begin
        s_ddr = 1'b1;
        s_two = 1'b1;
      end
    endcase
    case (se) // RULE9
      LVL_GND: {s_14x, s_rise} = 2'h0;
      LVL_3_8: {s_14x, s_rise} = 2'h2;
      LVL_5_8: {s_14x, s_rise} = 2'h3;
      default: {s_14x, s_rise} = 2'h1;
    endcase
    case (of) // RULE10
      LVL_GND: {s_lsb, s_ob} = 2'h0;
      LVL_3_8: {s_lsb, s_ob} = 2'h1;
      LVL_5_8: {s_lsb, s_ob} = 2'h3;
      default: {s_lsb, s_ob} = 2'h2;
    endcase
    case (sel) // RULE7
      LVL_GND: {s_int, s_gain} = 2'h0;
      LVL_3_8: {s_int, s_gain} = 2'h1;
      LVL_5_8: {s_int, s_gain} = 2'h3;
      default: {s_int, s_gain} = 2'h2;
    endcase

    ovrd = q.r_mode[B_OVRD];
    if (ovrd) begin
      ddr = ~q.r_mode[B_RATE]; // RULE1
      next_q.two_wire = q.r_mode[B_WIRE];
      next_q.ser_14x = q.r_mode[B_SER];
      next_q.lsb_first = q.r_mode[B_ORDER];
      next_q.offset_binary = q.r_test[B_DF];
      next_q.capture_rising = ~ddr & q.r_mode[B_EDGE]; // RULE9
    end else begin
      ddr = s_ddr; // RULE1
      next_q.two_wire = s_two;
      next_q.ser_14x = s_14x;
      next_q.lsb_first = s_lsb;
      next_q.offset_binary = s_ob;
      next_q.capture_rising = ~ddr & s_rise; // RULE9
    end
    next_q.ddr_clock = ddr;

    if (par) begin
      next_q.gain_35db = s_gain; // RULE7
      next_q.ref_internal = s_int;
      pd_sw = q.m_sclk[1] & ~q.m_sdat[1]; // RULE6
      case ({q.m_sclk[1], q.m_sdat[1]}) // RULE6
        2'h1: next_q.pattern = PAT_SYNC;
        2'h3: next_q.pattern = PAT_DESKEW;
        default: next_q.pattern = PAT_NORMAL;
      endcase
    end else begin
      next_q.gain_35db = ovrd & q.r_mode[B_GAIN]; // RULE3
      next_q.ref_internal = q.r_pwr[B_REF]; // RULE4
      next_q.pattern = q.r_test[B_PAT +: 3]; // RULE5
      pd_sw = q.r_pwr[B_PDG];
    end
    next_q.global_pd = q.m_pdn[1] | pd_sw; // RULE2
    next_q.chan_pd = q.r_pwr[B_CHPD +: 4];
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign two_wire = q.two_wire;
  assign ddr_clock = q.ddr_clock;
  assign ser_14x = q.ser_14x;
  assign capture_rising = q.capture_rising;
  assign lsb_first = q.lsb_first;
  assign offset_binary = q.offset_binary;
  assign gain_35db = q.gain_35db;
  assign ref_internal = q.ref_internal;
  assign global_pd = q.global_pd;
  assign chan_pd = q.chan_pd;
  assign pattern = q.pattern;
endmodule // acsp_dev

// ---- core/acsp_host.sv ----
`timescale 1ns/1ps
module acsp_host
  import acsp_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  acsp_if.host link
);

  typedef enum logic [2:0] {
    H_RESET = 3'h0,
    H_RWAIT = 3'h1,
    H_IDLE = 3'h2,
    H_SETUP = 3'h3,
    H_HIGH = 3'h4,
    H_LOW = 3'h5,
    H_HOLD = 3'h6,
    H_GAP = 3'h7
  } acsp_hst_e;

  typedef struct packed {
    acsp_hst_e st;
    logic [3:0] cnt;
    logic [3:0] bits;
    logic [15:0] word;
    logic [15:0] cmd;
    logic pend;
    logic rst_req;
    logic [12:0] pins;
    logic sclk;
    logic sen_n;
    logic sdat;
    logic hrst;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } acsp_hst_s;

  acsp_hst_s q;
  acsp_hst_s next_q;

  always_comb begin
    logic wr;
    logic busy;
    wr = psel & penable & pwrite & q.pready & ~q.pslverr;
    busy = q.pend | q.rst_req | (q.st != H_IDLE);
    next_q = q;
    next_q.pready = psel & ~penable;
    next_q.pslverr = 1'b0;
    if (psel && !penable) begin
      next_q.prdata = 32'h0000_0000;
      case (paddr)
        HOST_CMD: next_q.prdata = {16'h0000, q.cmd};
        HOST_STAT: next_q.prdata = {30'h0000_0000, q.hrst, busy};
        HOST_PINS: next_q.prdata = {19'h0_0000, 1'b0, q.pins[11:0]};
        default: next_q.pslverr = 1'b1;
      endcase
    end
    // Commands arriving while busy are dropped, software polls first
    if (wr && paddr == HOST_CMD && !busy) begin
      next_q.cmd = pwdata[15:0];
      next_q.pend = 1'b1;
    end
    if (wr && paddr == HOST_PINS) begin
      next_q.pins = pwdata[12:0];
      next_q.pins[P_RST] = 1'b0;
      next_q.rst_req = pwdata[P_RST];
    end
    // Reserved strap stays grounded
    next_q.cnt = q.cnt - 4'h1;
    case (q.st)
      H_RESET: begin
        next_q.hrst = 1'b1; // RULE18
        if (q.cnt == 4'h0) begin
          next_q.hrst = 1'b0;
          next_q.cnt = RST_SEN_CYC - 4'h1; // RULE22
          next_q.st = H_RWAIT;
        end
      end
      H_RWAIT: begin
        if (q.cnt == 4'h0) begin
          next_q.st = H_IDLE;
        end
      end
      H_IDLE: begin
        next_q.cnt = 4'h0;
        next_q.hrst = q.pins[P_PAR]; // RULE20
        next_q.sclk = q.pins[P_PAR] & q.pins[P_SCLK];
        next_q.sdat = q.pins[P_PAR] & q.pins[P_SDAT];
        if (q.rst_req) begin
          // A pulse request written in this same cycle is kept
          next_q.rst_req = wr && paddr == HOST_PINS && pwdata[P_RST];
          next_q.hrst = 1'b1;
          next_q.cnt = RST_PULSE_CYC - 4'h1;
          next_q.st = H_RESET;
        end else if (q.hrst && !q.pins[P_PAR]) begin
          // Leaving strap mode releases reset, so select waits too
          next_q.cnt = RST_SEN_CYC - 4'h1; // RULE22
          next_q.st = H_RWAIT;
        end else if (q.pend && !q.pins[P_PAR] && !q.hrst) begin
          next_q.pend = 1'b0;
          next_q.word = q.cmd;
          next_q.bits = 4'h0;
          next_q.sclk = 1'b0;
          next_q.sen_n = 1'b0; // RULE13
          next_q.cnt = SEN_CYC - 4'h1;
          next_q.st = H_SETUP;
        end
      end
      H_SETUP: begin
        if (q.cnt == 4'h0) begin
          next_q.sclk = 1'b1;
          next_q.sdat = q.word[15]; // RULE16
          next_q.cnt = HALF_CYC - 4'h1; // RULE17
          next_q.st = H_HIGH;
        end
      end
      H_HIGH: begin
        if (q.cnt == 4'h0) begin
          next_q.sclk = 1'b0;
          next_q.cnt = HALF_CYC - 4'h1;
          next_q.st = H_LOW;
        end
      end
      H_LOW: begin
        if (q.cnt == 4'h0) begin
          if (q.bits == 4'hF) begin
            next_q.cnt = SEN_CYC - 4'h1;
            next_q.st = H_HOLD;
          end else begin
            next_q.bits = q.bits + 4'h1;
            next_q.word = {q.word[14:0], 1'b0};
            next_q.sclk = 1'b1;
            next_q.sdat = q.word[14];
            next_q.cnt = HALF_CYC - 4'h1;
            next_q.st = H_HIGH;
          end
        end
      end
      H_HOLD: begin
        if (q.cnt == 4'h0) begin
          next_q.sen_n = 1'b1;
          next_q.cnt = HALF_CYC - 4'h1;
          next_q.st = H_GAP;
        end
      end
      H_GAP: begin
        if (q.cnt == 4'h0) begin
          next_q.sdat = 1'b0;
          next_q.st = H_IDLE;
        end
      end
      default: begin
        next_q.st = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      q <= '{st: H_RESET, cnt: RST_PULSE_CYC - 4'h1, bits: 4'h0, word: 16'h0000,
             cmd: 16'h0000, pend: 1'b0, rst_req: 1'b0, pins: PINS_RESET,
             sclk: 1'b0, sen_n: 1'b1, sdat: 1'b0, hrst: 1'b1,
             prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0};
    end else begin
      q <= next_q;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign link.sclk = q.sclk;
  assign link.serial_select_n = q.sen_n;
  assign link.serial_data_in = q.sdat;
  assign link.hw_reset = q.hrst;
  assign link.pdn_pin = q.pins[P_PDN];
  assign link.select_level = q.pins[1:0];
  assign link.wire_clock_strap = q.pins[3:2];
  assign link.serialize_edge_strap = q.pins[5:4];
  assign link.reserved_strap = 2'h0; // RULE11
  assign link.order_format_strap = q.pins[7:6];
endmodule // acsp_host

// ---- verification/acsp_assertions.sv ----
`timescale 1ns/1ps
module acsp_assertions (
  input wire logic mclk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic serial_select_n,
  input wire logic serial_data_in,
  input wire logic hw_reset,
  input wire logic pdn_pin,
  input wire logic global_pd,
  input wire logic ddr_clock,
  input wire logic capture_rising
);
  logic [4:0] fall_cnt;
  logic sclk_q;
  // Falls counted per select period, cleared while deselected
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fall_cnt <= 5'h00;
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= sclk;
      if (serial_select_n) begin
        fall_cnt <= 5'h00;
      end else if (sclk_q && !sclk) begin
        fall_cnt <= fall_cnt + 5'h01;
      end
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  sequence s_low3;
    !sclk [*3];
  endsequence
  sequence s_setup;
    s_low3 ##1 sclk;
  endsequence
  AST_SETUP: assert property ($fell(serial_select_n) && !hw_reset |-> s_setup)
    else $error("shift clock rose too soon after select");
  AST_HIGH: assert property ($rose(sclk) && !serial_select_n && !hw_reset |-> sclk [*3])
    else $error("shift clock high phase too short");
  AST_LOW: assert property ($fell(sclk) && !serial_select_n && !hw_reset |-> s_low3)
    else $error("shift clock low phase too short");
  AST_DATA: assert property (!serial_select_n && $stable(serial_select_n) && !$rose(sclk)
    && !hw_reset |-> $stable(serial_data_in))
    else $error("serial data moved away from a rising edge");
  AST_HOLD: assert property ($rose(serial_select_n) |->
    !$past(sclk) && !$past(sclk, 2) && !$past(sclk, 3))
    else $error("select released too soon after last edge");
  AST_COUNT: assert property ($rose(serial_select_n) && !hw_reset |-> fall_cnt == 5'h10)
    else $error("frame did not carry sixteen bits");
  AST_PULSE: assert property ($rose(hw_reset) |-> hw_reset [*2])
    else $error("hardware reset pulse too short");
  AST_RSTSEN: assert property ($fell(hw_reset) |-> serial_select_n [*3])
    else $error("select low too soon after reset");
  AST_PD: assert property (pdn_pin [*6] |-> global_pd)
    else $error("power-down pin not obeyed");
  AST_EDGE: assert property (ddr_clock |-> !capture_rising)
    else $error("capture edge set with double-rate clock");
endmodule // acsp_assertions

// ---- verification/adc_config_serial_port_tb.sv ----
`timescale 1ns/1ps
module adc_config_serial_port_tb
  import acsp_pkg::*;
;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic psel, penable, pwrite, err, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic two_wire, ddr_clock, ser_14x, capture_rising, lsb_first, offset_binary;
  logic gain_35db, ref_internal, global_pd;
  logic [3:0] chan_pd;
  logic [2:0] pattern;
  logic [10:0] m00, m0a, m0d;
  logic [12:0] pins_m;
  int n_mismatch, check_count;
  wire [15:0] outs = {two_wire, ddr_clock, ser_14x, capture_rising, lsb_first,
    offset_binary, gain_35db, ref_internal, global_pd, chan_pd, pattern};
  always #5 mclk = ~mclk;
  acsp_if link_if();
  acsp_dev acsp_dev_inst(.mclk(mclk), .rst(rst), .link(link_if.dev), .two_wire(two_wire),
    .ddr_clock(ddr_clock), .ser_14x(ser_14x), .capture_rising(capture_rising),
    .lsb_first(lsb_first), .offset_binary(offset_binary), .gain_35db(gain_35db),
    .ref_internal(ref_internal), .global_pd(global_pd), .chan_pd(chan_pd), .pattern(pattern));
  acsp_host acsp_host_inst(.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link_if.host));
  acsp_assertions acsp_assertions_inst(.mclk(mclk), .rst(rst), .sclk(link_if.sclk),
    .serial_select_n(link_if.serial_select_n), .serial_data_in(link_if.serial_data_in),
    .hw_reset(link_if.hw_reset), .pdn_pin(link_if.pdn_pin), .global_pd(global_pd),
    .ddr_clock(ddr_clock), .capture_rising(capture_rising));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic close_out();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic hang(input string what);
    n_mismatch++;
    $display("Error %0t %s timed out", $time, what);
    close_out();
  endtask
  // Model of the expected outputs from pins and stored registers
  function automatic logic [15:0] exp_out();
    logic [1:0] wc, se, of, sl;
    logic ov, tw, ddr, s14, ri, lsb, ob, g, rf, gp;
    logic [3:0] cp;
    logic [2:0] pat;
    wc = pins_m[3:2];
    se = pins_m[5:4];
    of = pins_m[7:6];
    sl = pins_m[1:0];
    ov = m0d[B_OVRD];
    tw = ov ? m0d[B_WIRE] : wc[1];
    ddr = ov ? !m0d[B_RATE] : (wc != LVL_5_8);
    s14 = ov ? m0d[B_SER] : se[1] ^ se[0];
    ri = ov ? m0d[B_EDGE] : se[1];
    lsb = ov ? m0d[B_ORDER] : of[1];
    ob = ov ? m0a[B_DF] : of[1] ^ of[0];
    g = pins_m[P_PAR] ? sl[1] ^ sl[0] : ov & m0d[B_GAIN];
    rf = pins_m[P_PAR] ? sl[1] : m00[B_REF];
    gp = pins_m[P_PDN] | m00[B_PDG] | (pins_m[P_PAR] & pins_m[P_SCLK] & !pins_m[P_SDAT]);
    cp = m00[4:1];
    pat = m0a[7:5];
    if (pins_m[P_PAR]) begin
      pat = !pins_m[P_SDAT] ? PAT_NORMAL : (pins_m[P_SCLK] ? PAT_DESKEW : PAT_SYNC);
    end
    return {tw, ddr, s14, ri & !ddr, lsb, ob, g, rf, gp, cp, pat};
  endfunction
  task automatic check_out(input logic [15:0] exp);
    check_count++;
    if (outs !== exp) begin
      n_mismatch++;
      $display("Error %0t outputs %h expected %h", $time, outs, exp);
    end
  endtask
  task automatic check_rd(input logic [32:0] got, input logic [32:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %0t read %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) hang("bus");
  endtask
  task automatic wait_idle();
    int k;
    k = 0;
    do begin
      apb(1'b0, HOST_STAT, 32'h0);
      k++;
    end while (rd[0] !== 1'b0 && k < 300);
    if (rd[0] !== 1'b0) hang("busy");
  endtask
  // Word goes out as one frame; model updates only mapped addresses
  task automatic send(input logic [15:0] w);
    apb(1'b1, HOST_CMD, {16'h0000, w});
    apb(1'b0, HOST_CMD, 32'h0);
    check_rd({err, rd}, {17'h0, w});
    wait_idle();
    if (w[15:11] == ADDR_PWR && w[B_RST]) begin
      m00 = REG_RESET;
      m0a = REG_RESET;
      m0d = REG_RESET;
    end else if (w[15:11] == ADDR_PWR) m00 = w[10:0];
    else if (w[15:11] == ADDR_TEST) m0a = w[10:0];
    else if (w[15:11] == ADDR_MODE) m0d = w[10:0];
    repeat (20) @(posedge mclk);
    check_out(exp_out());
  endtask
  // Strap mode holds reset high with busy clear, so status is checked there instead of polled
  task automatic setp(input logic [12:0] p);
    apb(1'b1, HOST_PINS, {19'h0, p});
    pins_m = {1'b0, p[11:0]};
    if (p[P_RST] || p[P_PAR]) begin
      m00 = REG_RESET;
      m0a = REG_RESET;
      m0d = REG_RESET;
    end
    if (!p[P_PAR]) wait_idle();
    repeat (12) @(posedge mclk);
    check_out(exp_out());
    if (p[P_PAR]) begin
      apb(1'b0, HOST_STAT, 32'h0);
      check_rd({err, rd}, 33'h2);
    end
    apb(1'b0, HOST_PINS, 32'h0);
    check_rd({err, rd}, {20'h0, pins_m});
  endtask
  initial begin
    seed = 32'h0000000C;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {m00, m0a, m0d, pins_m} = '0;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    wait_idle();
    check_rd({err, rd}, 33'h0);
    check_out(exp_out());
    for (int i = 0; i < 4; i++) setp({5'h00, 2'(i), 2'(i), 2'(i), 2'(i)});
    for (int i = 0; i < 4; i++) setp({5'h00, 8'(rnd())});
    for (int i = 0; i < 5; i++) send({ADDR_MODE, 11'(rnd())});
    send({ADDR_MODE, 11'(rnd()) | 11'h420});
    for (int i = 0; i < 8; i++) send({ADDR_TEST, 2'(rnd()) & 2'h1, 1'b0, 3'(i), 5'h00});
    for (int i = 0; i < 3; i++) send({ADDR_PWR, 5'h00, 6'(rnd())});
    setp(13'h0100);
    setp(13'h0000);
    send({5'h03, 11'h7FF});
    send({ADDR_PWR, 11'h400});
    send({ADDR_MODE, 11'h7FF});
    setp(13'h1000);
    for (int i = 0; i < 16; i++) setp({1'b0, 2'(i), 1'b1, 7'h00, 2'(i >> 2)});
    apb(1'b1, HOST_CMD, {16'h0000, ADDR_PWR, 11'h020});
    m00 = 11'h020;
    setp(13'h0000);
    apb(1'b0, 8'h0C, 32'h0);
    check_rd({err, 32'h0}, {1'b1, 32'h0});
    close_out();
  end
  initial begin
    repeat (90000) @(posedge mclk);
    hang("run");
  end
endmodule // adc_config_serial_port_tb
